// File: porseq_pkg.sv
// Constants shared by the power-on sequencer files
package porseq_pkg;
  // Internal oscillator rate
  localparam int CLK_MHZ = 100;
  // Longest configuration load time, largest density
  localparam int CONFIG_LOAD_TIME_US = 450;
  // Entry delay after the last late I/O bank is powered
  localparam int BANK_LATE_US = 2;
  // Least time the core supply must sit at the deep-reset level
  localparam int DEEP_RESET_MIN_US = 10;
  // Cycle counts derived from the rate; all are whole numbers at 100 MHz
  localparam int CONFIG_LOAD_CYC = CONFIG_LOAD_TIME_US * CLK_MHZ;
  localparam int BANK_LATE_CYC = BANK_LATE_US * CLK_MHZ;
  localparam int DEEP_RESET_CYC = DEEP_RESET_MIN_US * CLK_MHZ;
  // Counter width and defaults
  localparam int CNT_W = 24;
  localparam int NUM_BANKS = 4;
  localparam int NUM_IO = 16;
  localparam logic SYNC_RST = 1'b0;
  // Sequencer states
  typedef enum logic [2:0] {
    PS_POWER_DOWN,
    PS_LOADING,
    PS_WAIT_BANKS,
    PS_BANK_DELAY,
    PS_USER
  } porseq_state_t;
endpackage

// File: porseq_sync_if.sv
// Synchronised supply-good and option pin levels
`timescale 1ns/100ps
interface porseq_sync_if #(
  parameter int NB = 4
);
  logic coreStartOk;
  logic coreDeepLow;
  logic [NB-1:0] bankGood;
  logic clearPinN;
  logic oePin;
  modport sync (output coreStartOk, coreDeepLow, bankGood, clearPinN, oePin);
  modport seq (input coreStartOk, coreDeepLow, bankGood, clearPinN, oePin);
endinterface

// File: porseq_pin_sync.sv
// Two-flop synchroniser for supply monitors and option pins
`timescale 1ns/100ps
module porseq_pin_sync
  import porseq_pkg::*;
#(
  parameter int NB = 4
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic coreStartRaw,
  input wire logic coreDeepLowRaw,
  input wire logic [NB-1:0] bankGoodRaw,
  input wire logic clearPinRawN,
  input wire logic oePinRaw,
  porseq_sync_if.sync syncBus
);
  localparam int W = NB + 4;
  logic [W-1:0] meta_q;
  logic [W-1:0] stable_q;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= {W{SYNC_RST}};
      stable_q <= {W{SYNC_RST}};
    end else begin
      meta_q <= {oePinRaw, clearPinRawN, bankGoodRaw, coreDeepLowRaw, coreStartRaw};
      stable_q <= meta_q;
    end
  end

  // Unpack the settled levels
  assign syncBus.coreStartOk = stable_q[0];
  assign syncBus.coreDeepLow = stable_q[1];
  assign syncBus.bankGood = stable_q[NB+1:2];
  assign syncBus.clearPinN = stable_q[NB+2];
  assign syncBus.oePin = stable_q[NB+3];
endmodule

// File: porseq_top.sv
// Power-on sequencer: configuration load, register clear and I/O release
`timescale 1ns/100ps
// Summary of operation
// - Any supply below threshold before user mode cuts every output driver.
// - Load starts when the core supply reaches the download start level.
// - Load plus user mode entry finishes within the sized load time.
// - Pins stay tri-stated with pull-ups before and during the load.
// - User mode waits until every I/O bank supply is good.
// - A late last bank gives user mode a fixed delay after it.
// - In user mode the pins go to user logic, pull-ups removed.
// - Supply monitors other than the deep core level are ignored once user mode is entered.
// - A brown-out sag in user mode raises nothing and recovers nothing.
// - A long deep core drop then rise restarts the load.
// - Registers are cleared and released before the tri-state release, unless the clear pin option is on.
// - With the clear option, clear holds until the clear pin goes high.
// - With the enable option, outputs stay off until the enable pin rises.
module porseq_top
  import porseq_pkg::*;
#(
  parameter int NB = NUM_BANKS,
  parameter int NIO = NUM_IO,
  parameter int CFG_CYC = CONFIG_LOAD_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic coreStartRaw,
  input wire logic coreDeepLowRaw,
  input wire logic [NB-1:0] bankGoodRaw,
  input wire logic global_clear_pin_n,
  input wire logic global_output_enable_pin,
  input wire logic optClearPinEn,
  input wire logic optOePinEn,
  input wire logic [NIO-1:0] userOe,
  output logic [NIO-1:0] pinOe,
  output logic supplyLowOutputCut,
  output logic ioForceTriState,
  output logic ioPullUpEn,
  output logic configLoadActive,
  output logic userRegClear,
  output logic userMode
);
  porseq_sync_if #(.NB(NB)) syncBus ();
  porseq_state_t state_q;
  porseq_state_t state_d;
  logic [CNT_W-1:0] loadCnt_q;
  logic [CNT_W-1:0] delayCnt_q;
  logic [CNT_W-1:0] deepCnt_q;
  logic clearRel_q;
  logic triRel_q;
  logic allBanks;
  logic deepHeld;
  logic loadDone;
  logic delayDone;

  porseq_pin_sync #(.NB(NB)) u_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .coreStartRaw(coreStartRaw),
    .coreDeepLowRaw(coreDeepLowRaw),
    .bankGoodRaw(bankGoodRaw),
    .clearPinRawN(global_clear_pin_n),
    .oePinRaw(global_output_enable_pin),
    .syncBus(syncBus.sync)
  );

  // Terminal count test shared by the counters
  function automatic logic cntAt(input logic [CNT_W-1:0] cnt, input int lim);
    cntAt = (cnt == CNT_W'(lim - 1));
  endfunction

  // Derived conditions
  assign allBanks = &syncBus.bankGood;
  assign loadDone = cntAt(loadCnt_q, CFG_CYC);
  assign delayDone = cntAt(delayCnt_q, BANK_LATE_CYC);
  assign deepHeld = syncBus.coreDeepLow && cntAt(deepCnt_q, DEEP_RESET_CYC);

  // Next state; a brown-out above the deep level is deliberately ignored in user mode, and returns to power-down before it
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PS_POWER_DOWN: begin
        if (syncBus.coreStartOk) begin
          state_d = PS_LOADING;
        end
      end
      PS_LOADING: begin
        if (!syncBus.coreStartOk) begin
          state_d = PS_POWER_DOWN;
        end else if (loadDone) begin
          state_d = allBanks ? PS_USER : PS_WAIT_BANKS;
        end
      end
      PS_WAIT_BANKS: begin
        if (!syncBus.coreStartOk) begin
          state_d = PS_POWER_DOWN;
        end else if (allBanks) begin
          state_d = PS_BANK_DELAY;
        end
      end
      PS_BANK_DELAY: begin
        if (!syncBus.coreStartOk) begin
          state_d = PS_POWER_DOWN;
        end else if (!allBanks) begin
          state_d = PS_WAIT_BANKS;
        end else if (delayDone) begin
          state_d = PS_USER;
        end
      end
      PS_USER: begin
        if (deepHeld) begin
          state_d = PS_POWER_DOWN;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= PS_POWER_DOWN;
    end else begin
      state_q <= state_d;
    end
  end

  // Configuration load timer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      loadCnt_q <= '0;
    end else if (state_q == PS_LOADING && !loadDone) begin
      loadCnt_q <= loadCnt_q + 1'b1;
    end else if (state_q != PS_LOADING) begin
      loadCnt_q <= '0;
    end
  end

  // Late bank entry delay timer
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      delayCnt_q <= '0;
    end else if (state_q == PS_BANK_DELAY && !delayDone) begin
      delayCnt_q <= delayCnt_q + 1'b1;
    end else if (state_q != PS_BANK_DELAY) begin
      delayCnt_q <= '0;
    end
  end

  // Deep-reset dwell timer, runs only in user mode
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      deepCnt_q <= '0;
    end else if (state_q == PS_USER && syncBus.coreDeepLow) begin
      if (!cntAt(deepCnt_q, DEEP_RESET_CYC)) begin
        deepCnt_q <= deepCnt_q + 1'b1;
      end
    end else begin
      deepCnt_q <= '0;
    end
  end

  // Register clear release, held by the clear pin when that option is on
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      clearRel_q <= 1'b0;
    end else begin
      clearRel_q <= (state_d == PS_USER) && (!optClearPinEn || syncBus.clearPinN);
    end
  end

  // Tri-state release follows the clear release unless the clear pin option is on
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      triRel_q <= 1'b0;
    end else begin
      triRel_q <= (state_d == PS_USER) && (clearRel_q || optClearPinEn)
        && (!optOePinEn || syncBus.oePin);
    end
  end

  // Status outputs
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      userMode <= 1'b0;
      configLoadActive <= 1'b0;
    end else begin
      userMode <= (state_d == PS_USER);
      configLoadActive <= (state_d == PS_LOADING);
    end
  end

  // Pin control; the supply cut reads raw levels so it acts without the clock
  assign supplyLowOutputCut = !userMode && (!coreStartRaw || !(&bankGoodRaw));
  assign ioForceTriState = !triRel_q;
  assign ioPullUpEn = !triRel_q;
  assign userRegClear = !clearRel_q;
  assign pinOe = userOe & {NIO{triRel_q && !supplyLowOutputCut}};

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  sequence lateBankSeen;
    state_q == PS_WAIT_BANKS && allBanks && syncBus.coreStartOk;
  endsequence

  a_cut_pins_off: assert property (supplyLowOutputCut |-> pinOe == '0)
    else $error("outputs driven while supply low");
  a_load_starts: assert property (state_q == PS_POWER_DOWN && syncBus.coreStartOk
    |=> configLoadActive)
    else $error("load did not start at start level");
  a_load_bound: assert property (state_q == PS_LOADING |-> loadCnt_q < CNT_W'(CFG_CYC))
    else $error("load ran past its time");
  a_pull_in_load: assert property (configLoadActive |-> ioForceTriState && ioPullUpEn)
    else $error("pins released during load");
  a_bank_gate: assert property (state_q != PS_USER && !allBanks |=> !userMode)
    else $error("user mode with a bank unpowered");
  a_late_delay: assert property (lateBankSeen |=> state_q == PS_BANK_DELAY)
    else $error("late bank delay not started");
  a_late_exact: assert property (state_q == PS_BANK_DELAY && state_d == PS_USER
    |-> delayCnt_q == CNT_W'(BANK_LATE_CYC - 1))
    else $error("late bank entry at wrong delay");
  a_pins_release: assert property (userMode && clearRel_q && !optOePinEn && !deepHeld
    |=> !ioForceTriState && !ioPullUpEn)
    else $error("pins not released in user mode");
  a_user_holds: assert property (state_q == PS_USER && !syncBus.coreDeepLow
    |=> state_q == PS_USER ##1 userMode)
    else $error("user mode left without deep reset");
  a_deep_restart: assert property (state_q == PS_USER && deepHeld
    |=> state_q == PS_POWER_DOWN ##1 !userMode)
    else $error("deep drop did not restart");
  a_clear_first: assert property ($fell(ioForceTriState) && !optClearPinEn
    |-> $past(!userRegClear))
    else $error("tri-state released before clear release");
  a_clear_pin: assert property (optClearPinEn && !syncBus.clearPinN |=> userRegClear)
    else $error("clear released while clear pin low");
  a_oe_pin: assert property (optOePinEn && !syncBus.oePin |=> ioForceTriState)
    else $error("outputs released while enable pin low");
endmodule

// File: porseq_supply_model.sv
// Board supply and option pin model facing the sequencer
`timescale 1ns/100ps
module porseq_supply_model (
  input wire logic sys_clk,
  input wire logic coreOnReq,
  input wire logic deepReq,
  input wire logic [3:0] bankOnReq,
  input wire logic clrRelReq,
  input wire logic oeReq,
  output logic coreStartRaw,
  output logic coreDeepLowRaw,
  output logic [3:0] bankGoodRaw,
  output logic clearPinN,
  output logic oePin
);
  // Core monitors; a deep drop always also removes the start level
  always_ff @(posedge sys_clk) begin
    coreStartRaw <= coreOnReq & ~deepReq;
    coreDeepLowRaw <= deepReq;
  end
  // Bank supplies settle one edge after the request
  always_ff @(posedge sys_clk) begin
    bankGoodRaw <= bankOnReq;
  end
  // External party releases the clear pin and raises the enable pin
  always_ff @(posedge sys_clk) begin
    clearPinN <= clrRelReq;
    oePin <= oeReq;
  end
endmodule

// File: porseq_top_bench.sv
// Self-checking bench for the power-on sequencer
`timescale 1ns/100ps
module porseq_top_bench
  import porseq_pkg::*;
;
  localparam int CFG = 50;
  logic sys_clk = 1'h0;
  logic reset_n = 1'h0;
  logic coreOn = 1'h0, deep = 1'h0, clrRel = 1'h0, oeReq = 1'h0;
  logic optClr = 1'h0, optOe = 1'h0;
  logic [3:0] bankOn = 4'h0;
  logic [15:0] userOe = 16'ha5c3;
  logic coreStartRaw, coreDeepLowRaw, clearPinN, oePin;
  logic [3:0] bankGoodRaw;
  logic [15:0] pinOe;
  logic cut, triQ, pullQ, loadQ, clrQ, userMode;
  int numErrors = 0;
  int nTests = 0;
  int n;
  porseq_supply_model u_porseq_supply_model (.sys_clk(sys_clk), .coreOnReq(coreOn),
    .deepReq(deep), .bankOnReq(bankOn), .clrRelReq(clrRel), .oeReq(oeReq),
    .coreStartRaw(coreStartRaw), .coreDeepLowRaw(coreDeepLowRaw),
    .bankGoodRaw(bankGoodRaw), .clearPinN(clearPinN), .oePin(oePin));
  porseq_top #(.NB(4), .NIO(16), .CFG_CYC(CFG)) u_porseq_top (.sys_clk(sys_clk),
    .reset_n(reset_n), .coreStartRaw(coreStartRaw), .coreDeepLowRaw(coreDeepLowRaw),
    .bankGoodRaw(bankGoodRaw), .global_clear_pin_n(clearPinN),
    .global_output_enable_pin(oePin), .optClearPinEn(optClr), .optOePinEn(optOe),
    .userOe(userOe), .pinOe(pinOe), .supplyLowOutputCut(cut), .ioForceTriState(triQ),
    .ioPullUpEn(pullQ), .configLoadActive(loadQ), .userRegClear(clrQ),
    .userMode(userMode));
  // Free-running 100 MHz clock
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic completeRun();
    $display("comparisons %0d mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      numErrors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  // Bounded wait for user mode to reach a level; n counts the edges
  task automatic waitMode(input logic v, input int lim);
    n = 0;
    #1;
    while (userMode !== v && n < lim) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (userMode !== v) begin
      numErrors++;
      $display("wrong value userMode wait expected %0h seen %0h", v, userMode);
      completeRun();
    end
  endtask
  // Reset with every supply off and the given option straps
  task automatic doReset(input logic oc, input logic oo);
    step(1);
    reset_n <= 1'h0;
    {coreOn, deep, clrRel, oeReq, bankOn} <= 8'h0;
    optClr <= oc;
    optOe <= oo;
    step(2);
    reset_n <= 1'h1;
    step(3);
    #1;
  endtask
  task automatic tBasic();
    doReset(1'h0, 1'h0);
    chk("cut while off", 1, cut);
    chk("pinOe while off", 0, pinOe);
    step(1);
    coreOn <= 1'h1;
    bankOn <= 4'hf;
    step(5);
    #1;
    chk("load active", 1, loadQ);
    chk("pull-up in load", 1, pullQ);
    chk("tri in load", 1, triQ);
    waitMode(1'h1, CFG + 4);
    chk("entry time", 1, n >= CFG - 4 && n <= CFG);
    chk("clear at entry", 0, clrQ);
    chk("tri at entry", 1, triQ);
    step(1);
    #1;
    chk("tri released", 0, triQ);
    chk("pull-up off", 0, pullQ);
    chk("pin enables", userOe, pinOe);
    step(1);
    coreOn <= 1'h0;
    bankOn <= 4'h7;
    step(6);
    #1;
    chk("mode after sag", 1, userMode);
    chk("no cut after sag", 0, cut);
    chk("pins after sag", userOe, pinOe);
    $display("test basic done");
  endtask
  task automatic tLateBankDeep();
    doReset(1'h0, 1'h0);
    step(1);
    coreOn <= 1'h1;
    bankOn <= 4'h7;
    step(4);
    #1;
    chk("cut bank low", 1, cut);
    step(CFG + 20);
    #1;
    chk("mode bank low", 0, userMode);
    chk("pull-up bank low", 1, pullQ);
    step(1);
    bankOn <= 4'hf;
    waitMode(1'h1, BANK_LATE_CYC + 20);
    chk("late entry", 1, n >= BANK_LATE_CYC && n <= BANK_LATE_CYC + 6);
    step(1);
    coreOn <= 1'h0;
    deep <= 1'h1;
    waitMode(1'h0, DEEP_RESET_CYC + 20);
    chk("deep time", 1, n >= DEEP_RESET_CYC && n <= DEEP_RESET_CYC + 8);
    step(1);
    #1;
    chk("tri after deep", 1, triQ);
    step(1);
    deep <= 1'h0;
    coreOn <= 1'h1;
    waitMode(1'h1, CFG + 10);
    chk("reload time", 1, n >= CFG && n <= CFG + 6);
    $display("test late bank and deep reset done");
  endtask
  task automatic tOptions();
    doReset(1'h1, 1'h1);
    step(1);
    coreOn <= 1'h1;
    bankOn <= 4'hf;
    waitMode(1'h1, CFG + 10);
    step(3);
    #1;
    chk("tri held by pin", 1, triQ);
    chk("clear held by pin", 1, clrQ);
    chk("pins held off", 0, pinOe);
    step(1);
    oeReq <= 1'h1;
    step(5);
    #1;
    chk("tri after pin", 0, triQ);
    chk("clear past tri", 1, clrQ);
    step(1);
    clrRel <= 1'h1;
    step(5);
    #1;
    chk("clear after pin", 0, clrQ);
    step(1);
    oeReq <= 1'h0;
    step(5);
    #1;
    chk("tri on pin low", 1, triQ);
    $display("test pin options done");
  endtask
  // Main sequence
  initial begin
    tBasic();
    tLateBankDeep();
    tOptions();
    completeRun();
  end
endmodule
